// ### flash_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Flash device model
// ************************************
module flash_dev_model #(
  parameter logic [7:0] MAN_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hc5 // Arbitrary value
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [18:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [int];
  logic [22:0] wlog [$];
  int busy_ns = 400; // Well inside the longest program time
  int step = 0;
  logic busy = 0, idm = 0, lock = 0, tgl = 0; // Powers up in array read
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n; // CE and WE may rise in the same step
  wire [22:0] w = {addr[14:0], din}; // Only low address bits decode
  initial dout = 8'h00;

  function automatic logic [7:0] rdm(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rdm

  task automatic start_busy();
    fork
      begin
        busy = 1;
        #(busy_ns) busy = 0;
      end
    join_none
  endtask : start_busy

  // Command decoder at the rising write strobe
  always @(negedge wr) begin
    wlog.push_back(w);
    if (step == 6) begin
      if (!(lock && addr < 19'h04000)) mem[addr] = rdm(addr) & din;
      start_busy();
      step = 0;
    end else if (din == 8'hf0) begin
      idm = 0;
      step = 0;
    end else case ({step[2:0], w})
      {3'd0, 23'h5555aa}, {3'd1, 23'h2aaa55}, {3'd2, 23'h555580}, {3'd3, 23'h5555aa},
      {3'd4, 23'h2aaa55}: step = step + 1;
      {3'd2, 23'h5555a0}: step = 6;
      {3'd2, 23'h555590}: begin idm = 1; step = 0; end
      {3'd5, 23'h555510}: begin mem.delete(); start_busy(); step = 0; end
      {3'd5, 23'h555540}: begin lock = 1; start_busy(); step = 0; end
      default: step = 0; // Broken sequences fall back to read
    endcase
  end

  // Each read strobe drives fresh data; a released bus shows the inverse
  always @(rd) if (rd) begin
    if (busy) begin tgl = ~tgl; dout = {1'b0, tgl, 6'h15}; end
    else if (idm) dout = addr[18:1] != 0 ? 8'hff : addr[0] ? DEV_CODE : MAN_CODE;
    else dout = rdm(addr);
  end else dout = ~dout;
endmodule : flash_dev_model
`default_nettype wire

// ### flash_host.sv
// Summary of operation
// - Between polling reads, CE and OE stay high at least 150 ns.
// - Only a change of the toggle line between reads is meaningful.
// - All polling reads use one constant address.
// - During chip erase, OE stays high while WE and CE are low.
// - Lockout is six writes AA,55,80,AA,55,40 at 5555/2AAA.
// - ID entry is AA,55,90; exit is a single F0 write.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_params.svh"

module flash_host
  import flash_host_pkg::*;
#(
  parameter int ERASE_TIMEOUT_CYCLES = `FH_EC_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_op_t cmd_op,
  input wire logic [18:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_timeout,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [18:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  // Assert at once, release two edges later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Command sequence tables
  // ****************************************************************
  localparam logic [2:0] WP_LAST = 3'(`FH_WP_CYC - 1);
  localparam logic [2:0] WPH_LAST = 3'(`FH_WPH_CYC - 1);
  localparam logic [2:0] ACC_LAST = 3'(`FH_ACC_CYC - 1);
  localparam logic [2:0] OEHP_LAST = 3'(`FH_OEHP_CYC - 1);
  localparam logic [27:0] BP_LIMIT = 28'(`FH_BP_MAX_CYC);
  localparam logic [27:0] EC_LIMIT = 28'(ERASE_TIMEOUT_CYCLES);

  // Number of write cycles for each command
  function automatic logic [2:0] seq_len(input cmd_op_t op);
    unique case (op)
      OP_PROGRAM: seq_len = 3'h4;
      OP_CHIP_ERASE: seq_len = 3'h6;
      OP_LOCKOUT: seq_len = 3'h6;
      OP_ID_ENTER: seq_len = 3'h3;
      OP_ID_EXIT: seq_len = 3'h1;
      default: seq_len = 3'h0;
    endcase
  endfunction : seq_len

  // Command byte of step idx; unlock prefix is common to all long sequences
  function automatic logic [7:0] seq_byte(input cmd_op_t op, input logic [2:0] idx);
    logic [7:0] third;
    logic [7:0] last;
    third = (op == OP_PROGRAM) ? `FH_BYTE_PROGRAM :
            (op == OP_ID_ENTER) ? `FH_BYTE_ID_ENTER : `FH_BYTE_SETUP;
    last = (op == OP_LOCKOUT) ? `FH_BYTE_LOCKOUT : `FH_BYTE_CHIP_ERASE;
    if (op == OP_ID_EXIT) begin
      seq_byte = `FH_BYTE_ID_EXIT;
    end else begin
      unique case (idx)
        3'h0: seq_byte = `FH_BYTE_UNLOCK1;
        3'h1: seq_byte = `FH_BYTE_UNLOCK2;
        3'h2: seq_byte = third;
        3'h3: seq_byte = `FH_BYTE_UNLOCK1;
        3'h4: seq_byte = `FH_BYTE_UNLOCK2;
        default: seq_byte = last;
      endcase
    end
  endfunction : seq_byte

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  state_t state_reg, state_next;
  cmd_op_t op_reg, op_sel;
  logic [18:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [2:0] step_reg;
  logic [2:0] cnt_reg;
  logic poll_reg;
  logic have_prev_reg, rd_seen_reg;
  logic [7:0] rd_reg;
  logic [7:0] prev_reg;
  logic [27:0] timer_reg;
  logic timeout_reg;

  wire accept = (state_reg == ST_IDLE) && cmd_valid;
  assign op_sel = accept ? cmd_op : op_reg; // Latches load only at this edge
  wire [18:0] addr_in = (cmd_op == OP_ID_READ) ? {18'h00000, cmd_addr[0]} : cmd_addr;
  wire [18:0] addr_sel = accept ? addr_in : addr_reg;
  wire [2:0] len_in = seq_len(cmd_op);
  wire [2:0] len_cur = seq_len(op_reg);
  wire phase_end_wr_low = (cnt_reg == WP_LAST);
  wire phase_end_wr_high = (cnt_reg == WPH_LAST);
  wire phase_end_rd_low = (cnt_reg == ACC_LAST);
  wire phase_end_rd_high = (cnt_reg == OEHP_LAST);
  wire last_step = (step_reg == len_cur - 3'h1);
  wire needs_poll = (op_reg == OP_PROGRAM) || (op_reg == OP_CHIP_ERASE) ||
                    (op_reg == OP_LOCKOUT);
  // Settled when two successive reads agree on the toggle line
  wire settled = have_prev_reg &&
                 (rd_reg[`FH_STATUS_TOGGLE_LINE] == prev_reg[`FH_STATUS_TOGGLE_LINE]);
  wire [27:0] limit = (op_reg == OP_CHIP_ERASE) ? EC_LIMIT : BP_LIMIT;
  wire expired = (timer_reg >= limit);

  // Next state of the strobe sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_valid) begin
          state_next = (len_in == 3'h0) ? ST_RD_LOW : ST_WR_LOW;
        end
      end
      ST_WR_LOW: begin
        if (phase_end_wr_low) begin
          state_next = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (phase_end_wr_high && last_step) begin
          state_next = needs_poll ? ST_RD_LOW : ST_DONE;
        end else if (phase_end_wr_high) begin
          state_next = ST_WR_LOW;
        end
      end
      ST_RD_LOW: begin
        if (phase_end_rd_low) begin
          state_next = ST_RD_HIGH;
        end
      end
      ST_RD_HIGH: begin
        if (phase_end_rd_high) begin
          state_next = (!poll_reg || settled || expired) ? ST_DONE : ST_RD_LOW;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Pin values, decoded from the next state and then registered
  // ****************************************************************
  wire wr_next = (state_next == ST_WR_LOW);
  wire rd_next = (state_next == ST_RD_LOW);
  wire wr_phase_next = wr_next || (state_next == ST_WR_HIGH);
  // Address and data are launched with the falling write strobe only
  wire wr_launch = wr_next && (state_reg != ST_WR_LOW);
  wire [2:0] step_pin = accept ? 3'h0 : (state_reg == ST_WR_HIGH) ? step_reg + 3'h1 : step_reg;
  wire [14:0] cmd_word_addr = (step_pin == 3'h1 || step_pin == 3'h4) ?
                              `FH_ADDR_SECOND : `FH_ADDR_FIRST;
  wire prog_data_next = (op_sel == OP_PROGRAM) && (step_pin == 3'h3);
  // Command cycles only decode low 15 address bits, upper bits driven low
  wire [18:0] wr_addr_next = prog_data_next ? addr_reg :
                             (op_sel == OP_ID_EXIT) ? 19'h00000 :
                             {4'h0, cmd_word_addr};
  wire [7:0] wr_data_next = prog_data_next ? wdata_reg : seq_byte(op_sel, step_pin);

  // Strobes: OE never falls during writes, both CE and OE rise between reads
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
    end else begin
      flash_ce_n <= !(wr_next || rd_next);
      flash_oe_n <= !rd_next;
      flash_we_n <= !wr_next;
      flash_dq_oe <= wr_phase_next;
    end
  end

  // Address and data hold over the whole write cycle; reads keep one address
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      flash_addr <= 19'h00000;
      flash_dq_out <= 8'h00;
    end else if (wr_launch) begin
      flash_addr <= wr_addr_next;
      flash_dq_out <= wr_data_next;
    end else if (rd_next) begin
      flash_addr <= addr_sel;
    end
  end

  // ****************************************************************
  // Command latch and sequence counters
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ;
      addr_reg <= 19'h00000;
      wdata_reg <= 8'h00;
      step_reg <= 3'h0;
      cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? 3'h0 : cnt_reg + 3'h1;
      if (accept) begin
        op_reg <= cmd_op;
        // ID reads force the upper lines low so bit zero picks the code
        addr_reg <= addr_in;
        wdata_reg <= cmd_data;
        step_reg <= 3'h0;
      end else if (state_reg == ST_WR_HIGH && phase_end_wr_high && !last_step) begin
        step_reg <= step_reg + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Toggle polling
  // ****************************************************************
  // Data is sampled on the last cycle of the read strobe, after access time
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      rd_reg <= 8'h00;
      prev_reg <= 8'h00;
      have_prev_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
      poll_reg <= 1'b0;
    end else if (accept) begin
      have_prev_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
      poll_reg <= 1'b0;
    end else if (state_reg == ST_RD_LOW && phase_end_rd_low) begin
      rd_reg <= flash_dq_in;
      prev_reg <= rd_reg;
      rd_seen_reg <= 1'b1;
      have_prev_reg <= poll_reg && rd_seen_reg; // Stale byte of an older command never counts
    end else if (state_reg == ST_WR_HIGH && phase_end_wr_high && last_step) begin
      poll_reg <= needs_poll;
    end
  end

  // Busy timer bounds the wait; a dead device cannot hang the host
  always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      timer_reg <= 28'h0000000;
      timeout_reg <= 1'b0;
    end else if (accept) begin
      timer_reg <= 28'h0000000;
      timeout_reg <= 1'b0;
    end else if (poll_reg && !expired) begin
      timer_reg <= timer_reg + 28'h0000001;
    end else if (state_reg == ST_RD_HIGH && phase_end_rd_high && poll_reg && !settled) begin
      timeout_reg <= expired;
    end
  end

  // ****************************************************************
  // User side
  // ****************************************************************
  assign cmd_ready = (state_reg == ST_IDLE);
  assign rsp_valid = (state_reg == ST_DONE);
  assign rsp_data = rd_reg;
  assign rsp_timeout = timeout_reg;

endmodule : flash_host
`default_nettype wire

// ### flash_host_params.svh
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ****************************************************************
// Clock and strobe timing
// ****************************************************************
`define FH_CLK_NS 40
`define FH_CLK_MHZ 25
`define FH_WRITE_PULSE_NS 90
`define FH_WRITE_HIGH_NS 90
`define FH_READ_ACCESS_NS 120
`define FH_READ_STROBE_HIGH_MIN_NS 150
`define FH_BYTE_PROGRAM_DURATION_MAX_US 50
`define FH_ERASE_CYCLE_MAX_S 10

// Least times round up to whole cycles
`define FH_WP_CYC ((`FH_WRITE_PULSE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WPH_CYC ((`FH_WRITE_HIGH_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_ACC_CYC ((`FH_READ_ACCESS_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_OEHP_CYC ((`FH_READ_STROBE_HIGH_MIN_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
// Longest times round down
`define FH_BP_MAX_CYC (`FH_BYTE_PROGRAM_DURATION_MAX_US * `FH_CLK_MHZ)
`define FH_EC_MAX_CYC (`FH_ERASE_CYCLE_MAX_S * `FH_CLK_MHZ * 1000000)

// ****************************************************************
// Command addresses and bytes
// ****************************************************************
`define FH_ADDR_FIRST 15'h5555
`define FH_ADDR_SECOND 15'h2aaa
`define FH_BYTE_UNLOCK1 8'haa
`define FH_BYTE_UNLOCK2 8'h55
`define FH_BYTE_PROGRAM 8'ha0
`define FH_BYTE_SETUP 8'h80
`define FH_BYTE_CHIP_ERASE 8'h10
`define FH_BYTE_LOCKOUT 8'h40
`define FH_BYTE_ID_ENTER 8'h90
`define FH_BYTE_ID_EXIT 8'hf0
`define FH_STATUS_TOGGLE_LINE 6

`endif

// ### flash_host_pkg.sv
package flash_host_pkg;

  // Host commands
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_CHIP_ERASE = 3'b010,
    OP_LOCKOUT = 3'b011,
    OP_ID_ENTER = 3'b100,
    OP_ID_EXIT = 3'b101,
    OP_ID_READ = 3'b110
  } cmd_op_t;

  // Strobe sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_LOW = 3'b001,
    ST_WR_HIGH = 3'b010,
    ST_RD_LOW = 3'b011,
    ST_RD_HIGH = 3'b100,
    ST_DONE = 3'b101
  } state_t;

endpackage : flash_host_pkg

// ### flash_host_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Strobe checker
// ************************************
module flash_host_properties
  import flash_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire cmd_op_t cmd_op,
  input wire logic [18:0] cmd_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Command taken on this edge
  wire take = cmd_valid && cmd_ready;

  AST_WRITE_OE_HIGH: assert property (
    !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe) else $error("oe low in write");
  AST_WRITE_FRAME: assert property (
    $fell(flash_we_n) |-> (!flash_we_n)[*3] ##1 flash_we_n[*3]) else $error("write frame");
  AST_WRITE_HOLD: assert property (
    $fell(flash_we_n) |=> ($stable(flash_addr) && $stable(flash_dq_out))[*5])
    else $error("write data moved");
  AST_READ_LOW: assert property (
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n && !flash_dq_oe)[*3] ##1 flash_oe_n)
    else $error("read strobe");
  AST_READ_GAP: assert property (
    $rose(flash_oe_n) |-> (flash_oe_n && flash_ce_n)[*4]) else $error("strobe high short");
  AST_POLL_ADDR: assert property (
    !flash_oe_n ##1 flash_oe_n[*4] ##1 !flash_oe_n |-> flash_addr == $past(flash_addr, 5))
    else $error("poll address moved");
  AST_ID_ADDR: assert property (
    take && cmd_op == OP_ID_READ |=> flash_addr == {18'h0, $past(cmd_addr[0])})
    else $error("id address");
  AST_ID_ENTER: assert property (
    take && cmd_op == OP_ID_ENTER |=> !flash_we_n && flash_addr[14:0] == 15'h5555
      && flash_dq_out == 8'haa) else $error("id entry start");
  AST_ID_EXIT: assert property (
    take && cmd_op == OP_ID_EXIT |=> !flash_we_n && flash_dq_out == 8'hf0)
    else $error("id exit write");
endmodule : flash_host_properties

bind flash_host flash_host_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// ### flash_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Testbench
// ************************************
module flash_host_tb
  import flash_host_pkg::*;
;
  localparam logic [7:0] MAN = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEV = 8'hc5; // Arbitrary value
  typedef struct {cmd_op_t op; logic [18:0] a; logic [7:0] d, e; bit chk;} row_t;
  logic clk_sys = 0, rst_n = 0, cmd_valid = 0, cmd_ready, rsp_valid, rsp_timeout;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  cmd_op_t cmd_op = OP_READ;
  logic [18:0] cmd_addr = 0, flash_addr;
  logic [7:0] cmd_data = 0, rsp_data, flash_dq_out, flash_dq_in;
  int fails = 0, comparisons = 0;
  logic [22:0] lock_seq [6] = '{23'h5555aa, 23'h2aaa55, 23'h555580, 23'h5555aa, 23'h2aaa55,
    23'h555540};
  row_t rows [13] = '{'{OP_PROGRAM, 19'h12345, 8'h5a, 8'h5a, 1},
    '{OP_READ, 19'h12345, 8'h00, 8'h5a, 1}, '{OP_ID_ENTER, 19'h0, 8'h00, 8'h00, 0},
    '{OP_ID_READ, 19'h0, 8'h00, MAN, 1}, '{OP_ID_READ, 19'h1, 8'h00, DEV, 1},
    '{OP_ID_EXIT, 19'h0, 8'h00, 8'h00, 0}, '{OP_READ, 19'h12345, 8'h00, 8'h5a, 1},
    '{OP_LOCKOUT, 19'h04000, 8'h00, 8'hff, 1}, '{OP_PROGRAM, 19'h00100, 8'h00, 8'hff, 1},
    '{OP_READ, 19'h00100, 8'h00, 8'hff, 1}, '{OP_PROGRAM, 19'h04000, 8'h3c, 8'h3c, 1},
    '{OP_CHIP_ERASE, 19'h12345, 8'h00, 8'hff, 1}, '{OP_READ, 19'h04000, 8'h00, 8'hff, 1}};

  flash_host #(.ERASE_TIMEOUT_CYCLES(200)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
  flash_dev_model #(.MAN_CODE(MAN), .DEV_CODE(DEV)) M (.ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .addr(flash_addr), .din(flash_dq_out), .dout(flash_dq_in));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : check

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // Entered just after a rising edge; outputs are looked at on falling edges
  task automatic run_cmd(input cmd_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (cmd_ready !== 1'b1 && n < 50);
    if (cmd_ready !== 1'b1) begin
      check(1'b0, "never ready");
      end_of_test();
    end
    @(posedge clk_sys) cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 3000);
    if (rsp_valid !== 1'b1) begin
      check(1'b0, "no response");
      end_of_test();
    end
    @(posedge clk_sys);
  endtask : run_cmd

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Table of ordinary commands, back to back
    foreach (rows[i]) begin
      run_cmd(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].chk) check(rsp_data === rows[i].e && rsp_timeout === 1'b0, "data");
    end
    // Write order of the lockout and the short identification exit
    M.wlog.delete();
    run_cmd(OP_LOCKOUT, 19'h04000, 8'h00);
    check(M.wlog.size() == 6, "lockout count");
    foreach (lock_seq[i]) check(M.wlog[i] === lock_seq[i], "lockout write");
    M.wlog.delete();
    run_cmd(OP_ID_EXIT, 19'h0, 8'h00);
    check(M.wlog.size() == 1 && M.wlog[0][7:0] === 8'hf0, "exit write");
    // Reset in the middle of a read drops every strobe at once
    cmd_op <= OP_READ;
    cmd_valid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmd_valid <= 1'b0;
    rst_n <= 1'b0;
    @(negedge clk_sys);
    check(flash_ce_n === 1'b1 && flash_oe_n === 1'b1 && flash_we_n === 1'b1
      && flash_dq_oe === 1'b0 && cmd_ready === 1'b1 && rsp_valid === 1'b0, "reset");
    @(posedge clk_sys) rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run_cmd(OP_READ, 19'h12345, 8'h00);
    check(rsp_data === 8'hff, "read after reset");
    // A device slower than the longest program time must be given up on
    M.busy_ns = 60000;
    run_cmd(OP_PROGRAM, 19'h20000, 8'h11);
    check(rsp_timeout === 1'b1, "no timeout");
    end_of_test();
  end
endmodule : flash_host_tb
`default_nettype wire
